/* pmic_seq_regs.vh */
`ifndef PMIC_SEQ_REGS_VH
`define PMIC_SEQ_REGS_VH

// byte addresses on the register bus
`define ADR_CTRL     8'h00
`define ADR_RESP     8'h04
`define ADR_SSAUX    8'h08
`define ADR_FREQ2    8'h0C
`define ADR_FLTSUM   8'h10
`define ADR_FLTTYPE  8'h14
`define ADR_STATUS   8'h18
`define ADR_DACLO    8'h1C
`define ADR_DACHI    8'h20

// control register fields
`define CTRL_GROUP_A_BOOST_RAIL    0
`define CTRL_IO_REF_GROUP    1
`define CTRL_BACKLIGHT_GROUP    2
`define CTRL_ALT_SEQUENCE_GROUP    3
`define CTRL_ALTSEQ  4
`define CTRL_ACCUR   5

// fault type nibble per regulator
`define FT_THERM     0
`define FT_OC        1
`define FT_SC        2
`define FT_OVUV      3

// reset values
`define RST_CTRL     6'h00
`define RST_RESP     8'hFF
`define RST_SSAUX    12'h000
`define RST_FREQ2    2'h0
`define RST_DAC      32'h8080_8080
// phase slot of regulators one to five, four phases
`define PHASE_MAP    10'h0E4

// regulators with a thermal sensor (seven has none)
`define THERM_MASK   8'hBF
`define CORE_MASK    8'h0E

// timing
`define CLK_KHZ      25000
`define RETRY_MS     10
`define OC_MS        10

`endif

/* pmic_seq_ctrl.v */
`timescale 1ns/1ns
`include "pmic_seq_regs.vh"
module pmic_seq_ctrl #(
  parameter TIMEOUT_CYC = `RETRY_MS * `CLK_KHZ,
  parameter OC_CYC      = `OC_MS * `CLK_KHZ
)(
  input  wire        clk,
  input  wire        rstn,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        refGood,
  input  wire [2:0]  freqSelPin,
  input  wire [2:0]  softStartPin,
  input  wire [7:0]  thermalHit,
  input  wire [7:0]  ocSoft,
  input  wire [7:0]  scHard,
  input  wire [7:0]  ovuvHit,
  input  wire [7:0]  inRegulation,
  output reg  [7:0]  regEn_q,
  output reg  [7:0]  curLimit_q,
  output reg         gateDrivePwm_q,
  output reg         porRelease_q,
  output reg  [2:0]  primaryFreq_q,
  output reg  [1:0]  secondaryFreq_q,
  output reg  [9:0]  phaseMap_q,
  output reg  [23:0] softStart_q,
  output reg  [63:0] dacCode_q,
  output reg         procRstOut_q,
  output reg         procRstOeN_q
);
  localparam [4:0] S_OFF  = 5'h01;
  localparam [4:0] S_CORE = 5'h02;
  localparam [4:0] S_RUN  = 5'h04;
  localparam [4:0] S_SHUT = 5'h08;
  localparam [4:0] S_RAMP = 5'h10;
  localparam integer RETRY_I = TIMEOUT_CYC;
  localparam integer OC_I    = OC_CYC;
  localparam [17:0] RETRY_N = RETRY_I[17:0];
  localparam [17:0] OC_N    = OC_I[17:0];

  function [31:0] bmerge;
    input [31:0] oldV;
    input [31:0] newV;
    input [3:0]  sel;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1)
        bmerge[k*8 +: 8] = sel[k] ? newV[k*8 +: 8] : oldV[k*8 +: 8];
    end
  endfunction

  // two-stage synchronisers for all pin inputs
  reg [46:0] sync1_q;
  reg [46:0] sync2_q;
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_q <= 47'h0;
      sync2_q <= 47'h0;
    end
    else
    begin
      sync1_q <= {refGood, freqSelPin, softStartPin, thermalHit, ocSoft, scHard, ovuvHit, inRegulation};
      sync2_q <= sync1_q;
    end
  end
  wire       refS   = sync2_q[46];
  wire [2:0] freqS  = sync2_q[45:43];
  wire [2:0] ssS    = sync2_q[42:40];
  wire [7:0] thS    = sync2_q[39:32] & `THERM_MASK;
  wire [7:0] ocS    = sync2_q[31:24];
  wire [7:0] scS    = sync2_q[23:16];
  wire [7:0] ovS    = sync2_q[15:8];
  wire [7:0] regS   = sync2_q[7:0];

  reg [4:0]  state_q;
  reg [5:0]  ctrl_q;
  reg [7:0]  resp_q;
  reg [11:0] ssAux_q;
  reg [31:0] fltType_q;
  reg [7:0]  kill_q;
  reg        retryUsed_q;
  reg        retryWait_q;
  reg [17:0] retryCnt_q;
  reg [2:0]  ssPin_q;
  reg        pendValid_q;
  reg [39:0] pend_q;

  wire       isRun  = state_q == S_RUN;
  wire       wbReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       wrReq  = wbReq & wb_we_i;
  wire       dupOk  = pendValid_q & (pend_q == {wb_adr_i, wb_dat_i});
  wire       wrGo   = wrReq & (~ctrl_q[`CTRL_ACCUR] | dupOk);
  wire [31:0] ctrlNew = bmerge({26'h0, ctrl_q}, wb_dat_i, wb_sel_i);
  wire [31:0] ssNew   = bmerge({20'h0, ssAux_q}, wb_dat_i, wb_sel_i);

  // soft overcurrent timers, one per regulator
  wire [7:0] ocExpire;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : ocT
      reg [17:0] cnt_q;
      always @(posedge clk or negedge rstn)
      begin
        if (!rstn)
          cnt_q <= 18'h0;
        else if (!ocS[g] || !regEn_q[g])
          cnt_q <= 18'h0;
        else if (cnt_q != OC_N)
          cnt_q <= cnt_q + 18'h1;
      end
      assign ocExpire[g] = ocS[g] & regEn_q[g] & (cnt_q == OC_N);
    end
  endgenerate

  // fault events
  wire [7:0] ovA      = ovS & resp_q & regEn_q;
  wire [7:0] newKill  = (scS & regEn_q) | ocExpire | ovA;
  wire       coreTherm = |(thS & `CORE_MASK);
  wire       coreOvA   = |(ovA & `CORE_MASK);
  wire       chipShut  = coreTherm | coreOvA;
  wire       coreSc    = |(scS & regEn_q & `CORE_MASK);
  wire       grpAThm   = thS[0];
  wire       grpCThm   = |thS[6:4];
  wire       grpDThm   = thS[7];
  wire [31:0] clrMask  = (wrGo && wb_adr_i == `ADR_FLTTYPE) ? bmerge(32'h0, wb_dat_i, wb_sel_i) : 32'h0;
  wire [7:0] clrReg;
  wire [31:0] fltSet;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : fl
      assign clrReg[g] = |clrMask[g*4 +: 4];
      assign fltSet[g*4 +: 4] = {ovS[g], scS[g] & regEn_q[g], ocS[g] & regEn_q[g], thS[g]};
    end
  endgenerate
  wire [7:0] fltSum;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : fs
      assign fltSum[g] = |fltType_q[g*4 +: 4];
    end
  endgenerate

  // next state of the sequencer
  reg [4:0] state_d;
  always @*
  begin
    state_d = state_q;
    case (state_q)
      S_OFF:
        if (refS)
          state_d = S_RAMP;
      S_RAMP:
        state_d = S_CORE;
      S_CORE:
        if (chipShut)
          state_d = S_SHUT;
        else if (&regS[3:1])
          state_d = S_RUN;
      S_RUN:
        if (chipShut)
          state_d = S_SHUT;
      S_SHUT:
        if (!(|(thS & `CORE_MASK)) && !(|(ovS & `CORE_MASK)))
          state_d = S_CORE;
      default:
        state_d = S_OFF;
    endcase
  end

  // wanted enables per regulator, by group
  reg [7:0] want;
  always @*
  begin
    want = 8'h0;
    if ((state_q == S_CORE || isRun) && !retryWait_q)
      want[3:1] = 3'b111;
    if (isRun)
    begin
      want[0] = ctrl_q[`CTRL_GROUP_A_BOOST_RAIL];
      want[4] = ctrl_q[`CTRL_ALTSEQ] ? ctrl_q[`CTRL_ALT_SEQUENCE_GROUP] : ctrl_q[`CTRL_IO_REF_GROUP];
      want[5] = ctrl_q[`CTRL_IO_REF_GROUP];
      want[6] = ctrl_q[`CTRL_IO_REF_GROUP];
      want[7] = ctrl_q[`CTRL_BACKLIGHT_GROUP];
    end
  end

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      state_q <= S_OFF;
    else
      state_q <= state_d;
  end

  // register writes
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_q          <= `RST_CTRL;
      resp_q          <= `RST_RESP;
      ssAux_q         <= `RST_SSAUX;
      secondaryFreq_q <= `RST_FREQ2;
      dacCode_q       <= {`RST_DAC, `RST_DAC};
      pendValid_q     <= 1'b0;
      pend_q          <= 40'h0;
    end
    else
    begin
      if (wrReq && ctrl_q[`CTRL_ACCUR])
      begin
        pendValid_q <= ~dupOk;
        pend_q      <= {wb_adr_i, wb_dat_i};
      end
      if (wrGo && wb_adr_i == `ADR_CTRL)
        ctrl_q <= ctrlNew[5:0] & {2'b11, {4{isRun}}};
      else if (state_q == S_SHUT)
        ctrl_q[3:0] <= 4'h0;
      else
      begin
        if (grpAThm)
          ctrl_q[`CTRL_GROUP_A_BOOST_RAIL] <= 1'b0;
        if (grpCThm)
        begin
          ctrl_q[`CTRL_IO_REF_GROUP] <= 1'b0;
          ctrl_q[`CTRL_ALT_SEQUENCE_GROUP] <= 1'b0;
        end
        if (grpDThm)
          ctrl_q[`CTRL_BACKLIGHT_GROUP] <= 1'b0;
      end
      if (wrGo && wb_adr_i == `ADR_RESP)
        resp_q <= wb_dat_i[7:0] & {8{wb_sel_i[0]}} | resp_q & {8{~wb_sel_i[0]}};
      if (wrGo && isRun && wb_adr_i == `ADR_SSAUX)
        ssAux_q <= ssNew[11:0];
      if (wrGo && isRun && wb_adr_i == `ADR_FREQ2 && wb_sel_i[0])
        secondaryFreq_q <= wb_dat_i[1:0];
      if (wrGo && wb_adr_i == `ADR_DACLO)
        dacCode_q[31:0] <= bmerge(dacCode_q[31:0], wb_dat_i, wb_sel_i);
      if (wrGo && wb_adr_i == `ADR_DACHI)
        dacCode_q[63:32] <= bmerge(dacCode_q[63:32], wb_dat_i, wb_sel_i);
    end
  end

  // faults, kill mask and core retry
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      fltType_q   <= 32'h0;
      kill_q      <= 8'h0;
      retryUsed_q <= 1'b0;
      retryWait_q <= 1'b0;
      retryCnt_q  <= 18'h0;
    end
    else
    begin
      fltType_q <= (fltType_q & ~clrMask) | fltSet; // set wins over clear
      kill_q    <= (kill_q & ~clrReg) | (newKill & ~`CORE_MASK);
      if (state_q == S_SHUT)
      begin
        retryWait_q <= 1'b0;
        retryUsed_q <= 1'b0;
        kill_q[3:1] <= 3'b000;
      end
      else if (coreSc)
      begin
        kill_q[3:1] <= 3'b111;
        retryWait_q <= ~retryUsed_q;
        retryCnt_q  <= 18'h0;
      end
      else if (retryWait_q)
      begin
        if (retryCnt_q == RETRY_N)
        begin
          retryWait_q <= 1'b0;
          retryUsed_q <= 1'b1;
          kill_q[3:1] <= 3'b000;
        end
        else
          retryCnt_q <= retryCnt_q + 18'h1;
      end
      else if (|clrReg[3:1])
      begin
        kill_q[3:1] <= 3'b000;
        retryUsed_q <= 1'b0;
      end
    end
  end

  // outputs toward the power stages
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      regEn_q        <= 8'h0;
      curLimit_q     <= 8'h0;
      gateDrivePwm_q <= 1'b0;
      porRelease_q   <= 1'b0;
      primaryFreq_q  <= 3'h0;
      ssPin_q        <= 3'h0;
      phaseMap_q     <= `PHASE_MAP;
      softStart_q    <= 24'h0;
      procRstOut_q   <= 1'b0;
      procRstOeN_q   <= 1'b0;
    end
    else
    begin
      regEn_q    <= want & ~kill_q & ~newKill & ~(retryWait_q ? `CORE_MASK : 8'h0) & ~{8{chipShut}};
      curLimit_q <= ocS & regEn_q & ~ocExpire;
      if (state_q == S_OFF && refS)
        porRelease_q <= 1'b1;
      if (state_q == S_RAMP)
      begin
        primaryFreq_q  <= freqS;
        ssPin_q        <= ssS;
        gateDrivePwm_q <= 1'b1;
      end
      phaseMap_q   <= `PHASE_MAP;
      softStart_q  <= {ssAux_q, {4{ssPin_q}}};
      procRstOut_q <= 1'b0;
      procRstOeN_q <= isRun & (state_d == S_RUN);
    end
  end

  // bus answer, one cycle after the request
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wbReq;
      wb_dat_o <= 32'h0;
      if (wbReq && !wb_we_i)
      begin
        if (wb_adr_i == `ADR_CTRL)
          wb_dat_o <= {26'h0, ctrl_q};
        else if (wb_adr_i == `ADR_RESP)
          wb_dat_o <= {24'h0, resp_q};
        else if (wb_adr_i == `ADR_SSAUX)
          wb_dat_o <= {20'h0, ssAux_q};
        else if (wb_adr_i == `ADR_FREQ2)
          wb_dat_o <= {30'h0, secondaryFreq_q};
        else if (wb_adr_i == `ADR_FLTSUM)
          wb_dat_o <= {24'h0, fltSum};
        else if (wb_adr_i == `ADR_FLTTYPE)
          wb_dat_o <= fltType_q;
        else if (wb_adr_i == `ADR_STATUS)
          wb_dat_o <= {3'h0, retryUsed_q, retryWait_q, state_q, 3'h0, primaryFreq_q, curLimit_q, regEn_q};
        else if (wb_adr_i == `ADR_DACLO)
          wb_dat_o <= dacCode_q[31:0];
        else if (wb_adr_i == `ADR_DACHI)
          wb_dat_o <= dacCode_q[63:32];
      end
    end
  end

endmodule

/* pmic_seq_props.sv */
`timescale 1ns/1ns
`include "pmic_seq_regs.vh"
module pmic_seq_props (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic [7:0] thermalHit,
  input wire logic [7:0] scHard,
  input wire logic [7:0] regEn_q,
  input wire logic       gateDrivePwm_q,
  input wire logic       porRelease_q,
  input wire logic [2:0] primaryFreq_q,
  input wire logic [9:0] phaseMap_q,
  input wire logic       procRstOeN_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence reqTaken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence coreHot;
    (thermalHit[3:1] != 3'h0) [*5];
  endsequence
  sequence coreShort;
    $rose(scHard[1]) ##1 scHard[1] [*3];
  endsequence
  ack_timing_a: assert property (reqTaken |=> wb_ack_o) else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  core_therm_a: assert property (coreHot |-> regEn_q == 8'h00) else $error("chip not off");
  core_short_a: assert property (coreShort |=> !regEn_q[1]) else $error("short not cut");
  rst_release_a: assert property ($rose(procRstOeN_q) |-> regEn_q[3:1] == 3'h7) else $error("early release");
  por_sticky_a: assert property (porRelease_q |=> porRelease_q) else $error("release dropped");
  pre_por_a: assert property (!porRelease_q |-> regEn_q == 8'h00 && !gateDrivePwm_q) else $error("early on");
  phase_map_a: assert property (phaseMap_q == `PHASE_MAP) else $error("phase map");
  frequency_select_pin_hold_a: assert property (porRelease_q && $past(porRelease_q, 2) |-> $stable(primaryFreq_q))
    else $error("frequency_select_pin moved");
endmodule

/* rail_stage_model.sv */
`timescale 1ns/1ns
module rail_stage_model (
  input wire logic       clk,
  input wire logic       slow,
  input wire logic [7:0] regEn,
  output logic     [7:0] inRegulation
);
  logic [7:0] ramp_q [0:9];
  always @(posedge clk)
  begin
    ramp_q[0] <= regEn;
    for (int i = 1; i < 10; i++)
      ramp_q[i] <= ramp_q[i - 1];
  end
  // drops at once when disabled, rises after the ramp
  assign inRegulation = regEn & (slow ? ramp_q[9] : ramp_q[2]);
endmodule

/* pmic_seq_ctrl_tb.sv */
`timescale 1ns/1ns
`include "pmic_seq_regs.vh"
module pmic_seq_ctrl_tb;
  logic        clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, refGood = 0, slow = 0;
  logic [7:0]  adr = 8'h00, thermalHit = 8'h00, ocSoft = 8'h00, scHard = 8'h00, ovuvHit = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, r;
  wire  [31:0] rdat;
  wire  [7:0]  inRegulation, regEn_q, curLimit_q;
  wire         ack, gateDrivePwm_q, porRelease_q, procRstOeN_q, procRstOut_q;
  wire  [9:0]  phaseMap_q;
  wire  [2:0]  primaryFreq_q;
  wire  [1:0]  secondaryFreq_q;
  wire  [23:0] softStart_q;
  wire  [63:0] dacCode_q;
  int          bad_count = 0, check_count = 0, cycles = 0;

  pmic_seq_ctrl #(.TIMEOUT_CYC(20), .OC_CYC(20)) i_dut (
    .clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .refGood(refGood),
    .freqSelPin(3'h5), .softStartPin(3'h3), .thermalHit(thermalHit), .ocSoft(ocSoft),
    .scHard(scHard), .ovuvHit(ovuvHit), .inRegulation(inRegulation), .regEn_q(regEn_q),
    .curLimit_q(curLimit_q), .gateDrivePwm_q(gateDrivePwm_q), .porRelease_q(porRelease_q),
    .primaryFreq_q(primaryFreq_q), .secondaryFreq_q(secondaryFreq_q), .phaseMap_q(phaseMap_q),
    .softStart_q(softStart_q), .dacCode_q(dacCode_q), .procRstOut_q(procRstOut_q), .procRstOeN_q(procRstOeN_q));
  rail_stage_model i_rails (.clk(clk), .slow(slow), .regEn(regEn_q), .inRegulation(inRegulation));

  always #20 clk = ~clk;

  task end_sim;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      end_sim();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    // wait for the answer; only the global cycle limit ends this
    while (ack !== 1'b1)
      @(posedge clk);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(r, e);
  endtask

  task waitEn(input logic [7:0] m, input logic [7:0] v);
    int n;
    n = 0;
    while ((regEn_q & m) !== v && n < 80)
    begin
      @(posedge clk);
      n++;
    end
    chk(32'(regEn_q & m), 32'(v));
  endtask

  task waitRst;
    int n;
    n = 0;
    while (procRstOeN_q !== 1'b1 && n < 80)
    begin
      @(posedge clk);
      n++;
    end
    chk(32'(procRstOeN_q), 32'h0000_0001);
  endtask

  task clearFaults;
    repeat (4) @(posedge clk);
    wr(`ADR_FLTTYPE, 32'hFFFF_FFFF);
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(`ADR_RESP, 32'h0000_00FF);
    rd(`ADR_DACLO, 32'h8080_8080);
    rd(8'h40, 32'h0000_0000);
    wr(`ADR_CTRL, 32'h0000_0006);
    rd(`ADR_CTRL, 32'h0000_0000);
    chk(32'(procRstOeN_q), 32'h0000_0000);
    chk(32'(procRstOut_q), 32'h0000_0000);
    $display("registers done");
    refGood <= 1'b1;
    waitEn(8'h0E, 8'h0E);
    waitRst();
    chk(32'(primaryFreq_q), 32'h0000_0005);
    chk(32'(phaseMap_q), 32'(`PHASE_MAP));
    chk(32'(softStart_q[11:0]), 32'h0000_06DB);
    chk(32'(gateDrivePwm_q), 32'h0000_0001);
    $display("power up done");
    wr(`ADR_CTRL, 32'h0000_0006);
    waitEn(8'hF0, 8'hF0);
    wr(`ADR_CTRL, 32'h0000_001C);
    waitEn(8'hF0, 8'h90);
    wr(`ADR_CTRL, 32'h0000_0006);
    waitEn(8'hF0, 8'hF0);
    thermalHit <= 8'h40;
    repeat (8) @(posedge clk);
    chk(32'(regEn_q), 32'h0000_00FE);
    thermalHit <= 8'h20;
    waitEn(8'hF0, 8'h80);
    rd(`ADR_FLTSUM, 32'h0000_0020);
    rd(`ADR_FLTTYPE, 32'h0010_0000);
    thermalHit <= 8'h00;
    clearFaults();
    rd(`ADR_FLTSUM, 32'h0000_0000);
    $display("groups done");
    wr(`ADR_CTRL, 32'h0000_0006);
    wr(`ADR_RESP, 32'h0000_007F);
    ovuvHit <= 8'h90;
    waitEn(8'hF0, 8'hE0);
    rd(`ADR_FLTSUM, 32'h0000_0090);
    chk(32'(regEn_q[7]), 32'h0000_0001);
    ovuvHit <= 8'h00;
    clearFaults();
    wr(`ADR_CTRL, 32'h0000_0026);
    wr(`ADR_FREQ2, 32'h0000_0002);
    chk(32'(secondaryFreq_q), 32'h0000_0000);
    wr(`ADR_FREQ2, 32'h0000_0002);
    chk(32'(secondaryFreq_q), 32'h0000_0002);
    repeat (2) wr(`ADR_DACHI, 32'h1122_3344);
    chk(dacCode_q[63:32], 32'h1122_3344);
    repeat (2) wr(`ADR_SSAUX, 32'h0000_0FAC);
    chk(32'(softStart_q[23:12]), 32'h0000_0FAC);
    repeat (2) wr(`ADR_CTRL, 32'h0000_0006);
    $display("response and serial done");
    ocSoft <= 8'h80;
    repeat (5) @(posedge clk);
    chk(32'({regEn_q[7], curLimit_q}), 32'h0000_0180);
    waitEn(8'h80, 8'h00);
    ocSoft <= 8'h00;
    clearFaults();
    slow <= 1'b1;
    thermalHit <= 8'h04;
    waitEn(8'hFF, 8'h00);
    chk(32'(procRstOeN_q), 32'h0000_0000);
    thermalHit <= 8'h00;
    waitRst();
    clearFaults();
    // core over/undervoltage with response A stops the chip
    ovuvHit <= 8'h04;
    waitEn(8'hFF, 8'h00);
    chk(32'(procRstOeN_q), 32'h0000_0000);
    ovuvHit <= 8'h00;
    waitRst();
    clearFaults();
    scHard <= 8'h02;
    waitEn(8'h0E, 8'h00);
    scHard <= 8'h00;
    waitEn(8'h0E, 8'h0E);
    scHard <= 8'h02;
    waitEn(8'h0E, 8'h00);
    scHard <= 8'h00;
    repeat (60) @(posedge clk);
    chk(32'(regEn_q & 8'h0E), 32'h0000_0000);
    rd(`ADR_FLTTYPE, 32'h0000_0040);
    wr(`ADR_FLTTYPE, 32'h0000_00F0);
    waitEn(8'h0E, 8'h0E);
    $display("faults done");
    end_sim();
  end
endmodule

bind pmic_seq_ctrl pmic_seq_props i_props (
  .clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .thermalHit(thermalHit), .scHard(scHard), .regEn_q(regEn_q), .gateDrivePwm_q(gateDrivePwm_q),
  .porRelease_q(porRelease_q), .primaryFreq_q(primaryFreq_q), .phaseMap_q(phaseMap_q),
  .procRstOeN_q(procRstOeN_q));
